// ===== src/pos_irq_cfg.svh
// Offsets, field positions, reset values and timing counts of the decoder interrupt and event block.
// Assumes it is included by bare name from the package and the design modules.
`ifndef POS_IRQ_CFG_SVH
`define POS_IRQ_CFG_SVH

`define MATCH_CHANNELS   2
`define SOURCES          (4 + `MATCH_CHANNELS)
`define ADDR_DECODE_BITS 12

`define OFS_CTRL         12'h000
`define OFS_EVCTRL       12'h004
`define OFS_UNMASK_CLEAR 12'h008
`define OFS_UNMASK_SET   12'h00C
`define OFS_PENDING      12'h010
`define OFS_SYNCBUSY     12'h014
`define OFS_STATUS       12'h018

`define CTRL_SOFT_RESET  0
`define CTRL_ENABLE      1
`define CTRL_MODE_LO     2
`define CTRL_MODE_HI     3
`define CTRL_KEEP_ALIVE  6

`define SRC_WRAP         0
`define SRC_FAULT        1
`define SRC_SPEED        2
`define SRC_REVERSAL     3
`define SRC_MATCH0       4

`define BUSY_SOFT_RESET  0
`define BUSY_ENABLE      1
`define STAT_ENABLED     0
`define STAT_RUNNING     1

`define MODE_RESET       2'h0
`define SYNC_DELIVERY    4

`endif

// ===== src/pos_irq_pkg.sv
// Types shared by the decoder interrupt and event block.
// Assumes the configuration header is on the include path.
`include "pos_irq_cfg.svh"

package pos_irq_pkg;

  typedef enum logic [1:0] {
    MODE_QUADRATURE = 2'h0,
    MODE_COMMUTATION = 2'h1,
    MODE_COUNTER     = 2'h3
  } decode_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [`MATCH_CHANNELS-1:0] match;
    logic                       reversal;
    logic                       speed;
    logic                       fault;
    logic                       wrap;
  } hit_t;

  typedef struct packed {
    logic flag;
    logic unmask;
    logic evt_en;
    logic evt_out;
  } flag_state_t;

  typedef struct packed {
    logic tgl;
    logic data;
    logic d1;
    logic d2;
    logic d3;
    logic done;
    logic dout;
  } sync_state_t;

endpackage : pos_irq_pkg

// ===== src/sync_handshake.sv
// Carries one written control bit through a toggle and three-stage chain into the decoder domain.
// Assumes a single launch pulse per transfer; launches while busy are ignored.
`timescale 1ns/1ps
`default_nettype none

module sync_handshake (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic launch,
  input  wire logic din,
  output var  logic busy,
  output var  logic done,
  output var  logic dout
);
  import pos_irq_pkg::*;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st = st;
    if (launch && !busy) begin
      next_st.tgl  = ~st.tgl;
      next_st.data = din;
    end
    next_st.d1   = st.tgl;
    next_st.d2   = st.d1;
    next_st.d3   = st.d2;
    next_st.done = st.d2 ^ st.d3;
    if (st.d2 ^ st.d3) begin
      next_st.dout = st.data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.tgl ^ st.d3;
  assign done = st.done;
  assign dout = st.dout;

  a_sync_delivery_delay: assert property (@(posedge mclk) disable iff (reset)
    (launch && !busy) |-> ##4 done)
    else $error("Synchronised write not delivered after four cycles.");

  a_sync_busy_shown: assert property (@(posedge mclk) disable iff (reset)
    (launch && !busy) |=> busy [*3])
    else $error("Busy not shown while a write is synchronised.");

endmodule : sync_handshake

`default_nettype wire

// ===== src/source_flag.sv
// One interrupt and event source: sticky pending flag, unmask bit, event enable and event pulse.
// Assumes hit is a same-clock pulse already gated by mode and run state.
`timescale 1ns/1ps
`default_nettype none

module source_flag (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic srst,
  input  wire logic hit,
  input  wire logic unmask_set,
  input  wire logic unmask_clear,
  input  wire logic flag_clear,
  input  wire logic evt_wr,
  input  wire logic evt_wdata,
  output var  logic flag,
  output var  logic unmask,
  output var  logic evt_en,
  output var  logic evt_out
);
  import pos_irq_pkg::*;

  flag_state_t st;
  flag_state_t next_st;

  always_comb begin
    next_st = st;
    if (flag_clear) begin
      next_st.flag = 1'b0;
    end
    if (hit) begin
      next_st.flag = 1'b1;
    end
    if (unmask_set) begin
      next_st.unmask = 1'b1;
    end else if (unmask_clear) begin
      next_st.unmask = 1'b0;
    end
    if (evt_wr) begin
      next_st.evt_en = evt_wdata;
    end
    next_st.evt_out = hit & st.evt_en;
    if (srst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag    = st.flag;
  assign unmask  = st.unmask;
  assign evt_en  = st.evt_en;
  assign evt_out = st.evt_out;

  a_flag_set_wins: assert property (@(posedge mclk) disable iff (reset)
    (hit && !srst) |=> flag)
    else $error("Pending flag lost on a source hit.");

  a_event_needs_enable: assert property (@(posedge mclk) disable iff (reset)
    evt_out |-> ($past(evt_en) && $past(hit)))
    else $error("Event emitted while its output was disabled.");

endmodule : source_flag

`default_nettype wire

// ===== src/position_irq_event.sv
// Interrupt, event output, sleep and enable logic of the position decoder, with an APB register slave.
// Assumes source hits are one-cycle pulses from the counting core on mclk; standby_in comes from outside.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pos_irq_cfg.svh"

module position_irq_event (
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire pos_irq_pkg::apb_req_t   apb,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire pos_irq_pkg::hit_t       hits,
  input  wire logic                    standby_in,
  output var  logic [`SOURCES-1:0]     event_out,
  output var  logic                    irq,
  output var  logic                    wake,
  output var  logic                    core_run,
  output var  logic                    core_soft_reset,
  output var  logic                    enabled,
  output var  pos_irq_pkg::decode_mode_t decode_mode
);
  import pos_irq_pkg::*;

  typedef struct packed {
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         keep_alive;
    decode_mode_t mode;
    logic         enable_req;
    logic         enable_active;
    logic         irq;
    logic         wake;
    logic         core_run;
    logic         soft_reset;
    logic         stby1;
    logic         stby2;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic [`SOURCES-1:0]          pend;
  logic [`SOURCES-1:0]          unmask;
  logic [`SOURCES-1:0]          evt_en;
  logic [`SOURCES-1:0]          src;
  logic [`ADDR_DECODE_BITS-1:0] addr;
  logic                         setup;
  logic                         access;
  logic                         wr;
  logic                         sel_ctrl;
  logic                         sel_evctrl;
  logic                         sel_uclr;
  logic                         sel_uset;
  logic                         sel_pend;
  logic                         sel_busy;
  logic                         sel_stat;
  logic                         mapped;
  logic                         mode_motion;
  logic                         busy_any;
  logic                         ctrl_wr;
  logic                         srst_launch;
  logic                         en_launch;
  logic                         srst_busy;
  logic                         srst_done;
  logic                         en_busy;
  logic                         en_done;
  logic                         en_dout;
  logic [31:0]                  rd_mux;

  // Bus decode; the slave answers in the first access cycle with no wait states.
  assign addr       = apb.paddr[`ADDR_DECODE_BITS-1:0];
  assign setup      = apb.psel & ~apb.penable;
  assign access     = apb.psel & apb.penable & st.pready;
  assign wr         = access & apb.pwrite & ~st.pslverr;
  assign sel_ctrl   = (addr == `OFS_CTRL);
  assign sel_evctrl = (addr == `OFS_EVCTRL);
  assign sel_uclr   = (addr == `OFS_UNMASK_CLEAR);
  assign sel_uset   = (addr == `OFS_UNMASK_SET);
  assign sel_pend   = (addr == `OFS_PENDING);
  assign sel_busy   = (addr == `OFS_SYNCBUSY);
  assign sel_stat   = (addr == `OFS_STATUS);
  assign mapped     = sel_ctrl | sel_evctrl | sel_uclr | sel_uset | sel_pend | sel_busy | sel_stat;

  // Control writes are ignored while either synchroniser is still busy.
  assign busy_any    = srst_busy | en_busy;
  assign ctrl_wr     = wr & sel_ctrl & ~busy_any;
  assign srst_launch = ctrl_wr & apb.pwdata[`CTRL_SOFT_RESET];
  assign en_launch   = ctrl_wr & ~apb.pwdata[`CTRL_SOFT_RESET];

  // Motion sources only exist in the two sensor modes.
  assign mode_motion = (st.mode == MODE_QUADRATURE) | (st.mode == MODE_COMMUTATION);

  always_comb begin
    src = hits & {`SOURCES{st.core_run}};
    src[`SRC_SPEED]    = hits.speed & st.core_run & mode_motion;
    src[`SRC_REVERSAL] = hits.reversal & st.core_run & mode_motion;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux[`CTRL_ENABLE]                   = st.enable_req;
      rd_mux[`CTRL_MODE_HI:`CTRL_MODE_LO]    = st.mode;
      rd_mux[`CTRL_KEEP_ALIVE]               = st.keep_alive;
    end else if (sel_evctrl) begin
      rd_mux[`SOURCES-1:0] = evt_en;
    end else if (sel_uclr || sel_uset) begin
      rd_mux[`SOURCES-1:0] = unmask;
    end else if (sel_pend) begin
      rd_mux[`SOURCES-1:0] = pend;
    end else if (sel_busy) begin
      rd_mux[`BUSY_SOFT_RESET] = srst_busy;
      rd_mux[`BUSY_ENABLE]     = en_busy;
    end else if (sel_stat) begin
      rd_mux[`STAT_ENABLED] = st.enable_active;
      rd_mux[`STAT_RUNNING] = st.core_run;
    end
  end

  sync_handshake u_srst_sync (
    .mclk   (mclk),
    .reset  (reset),
    .launch (srst_launch),
    .din    (1'b1),
    .busy   (srst_busy),
    .done   (srst_done),
    .dout   ()
  );

  sync_handshake u_enable_sync (
    .mclk   (mclk),
    .reset  (reset),
    .launch (en_launch),
    .din    (apb.pwdata[`CTRL_ENABLE]),
    .busy   (en_busy),
    .done   (en_done),
    .dout   (en_dout)
  );

  genvar g;
  generate
    for (g = 0; g < `SOURCES; g++) begin : g_src
      source_flag u_flag (
        .mclk         (mclk),
        .reset        (reset),
        .srst         (srst_done),
        .hit          (src[g]),
        .unmask_set   (wr & sel_uset & apb.pwdata[g]),
        .unmask_clear (wr & sel_uclr & apb.pwdata[g]),
        .flag_clear   (wr & sel_pend & apb.pwdata[g]),
        .evt_wr       (wr & sel_evctrl),
        .evt_wdata    (apb.pwdata[g]),
        .flag         (pend[g]),
        .unmask       (unmask[g]),
        .evt_en       (evt_en[g]),
        .evt_out      (event_out[g])
      );
    end
  endgenerate

  always_comb begin
    next_st         = st;
    next_st.pready  = setup;
    next_st.pslverr = setup & ~mapped;
    if (setup) begin
      next_st.prdata = rd_mux;
    end
    next_st.stby1      = standby_in;
    next_st.stby2      = st.stby1;
    next_st.core_run   = st.enable_active & (~st.stby2 | st.keep_alive);
    next_st.irq        = |(pend & unmask);
    next_st.wake       = (|(pend & unmask)) & st.stby2;
    next_st.soft_reset = srst_done;
    if (ctrl_wr && !apb.pwdata[`CTRL_SOFT_RESET]) begin
      next_st.enable_req = apb.pwdata[`CTRL_ENABLE];
      next_st.keep_alive = apb.pwdata[`CTRL_KEEP_ALIVE];
      next_st.mode       = decode_mode_t'(apb.pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
    end
    if (en_done) begin
      next_st.enable_active = en_dout;
    end
    if (srst_done) begin
      next_st.keep_alive    = 1'b0;
      next_st.mode          = decode_mode_t'(`MODE_RESET);
      next_st.enable_req    = 1'b0;
      next_st.enable_active = 1'b0;
      next_st.core_run      = 1'b0;
      next_st.irq           = 1'b0;
      next_st.wake          = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st      <= '0;
      st.mode <= decode_mode_t'(`MODE_RESET);
    end else begin
      st <= next_st;
    end
  end

  assign prdata          = st.prdata;
  assign pready          = st.pready;
  assign pslverr         = st.pslverr;
  assign irq             = st.irq;
  assign wake            = st.wake;
  assign core_run        = st.core_run;
  assign core_soft_reset = st.soft_reset;
  assign enabled         = st.enable_active;
  assign decode_mode     = st.mode;

  a_irq_follows_flags: assert property (@(posedge mclk) disable iff (reset)
    (|(pend & unmask)) && !srst_done |=> irq)
    else $error("Interrupt not raised for an unmasked pending flag.");

  a_irq_drops_cause: assert property (@(posedge mclk) disable iff (reset)
    !(|(pend & unmask)) |=> !irq)
    else $error("Interrupt stays high with no unmasked pending flag.");

  a_unmask_set_one: assert property (@(posedge mclk) disable iff (reset)
    (wr && sel_uset && apb.pwdata[`SRC_WRAP] && !srst_done) |=> unmask[`SRC_WRAP])
    else $error("Unmask set write did not enable the source.");

  a_unmask_set_zero: assert property (@(posedge mclk) disable iff (reset)
    (wr && sel_uset && !apb.pwdata[`SRC_FAULT] && !srst_done && !sel_uclr) |=> $stable(unmask[`SRC_FAULT]))
    else $error("Unmask set write of zero changed the source enable.");

  a_unmask_clear_one: assert property (@(posedge mclk) disable iff (reset)
    (wr && sel_uclr && apb.pwdata[`SRC_MATCH0]) |=> !unmask[`SRC_MATCH0])
    else $error("Unmask clear write did not disable the source.");

  a_motion_mode_gate: assert property (@(posedge mclk) disable iff (reset)
    (event_out[`SRC_SPEED] || event_out[`SRC_REVERSAL]) |-> $past(mode_motion))
    else $error("Speed or reversal event outside the sensor modes.");

  a_standby_stops_core: assert property (@(posedge mclk) disable iff (reset)
    (st.stby2 && !st.keep_alive) |=> !core_run)
    else $error("Decoder kept running in standby without keep-alive.");

  a_standby_keep_alive: assert property (@(posedge mclk) disable iff (reset)
    (st.stby2 && st.keep_alive && st.enable_active && !srst_done) |=> core_run)
    else $error("Decoder stopped in standby although keep-alive is set.");

  a_wake_on_irq: assert property (@(posedge mclk) disable iff (reset)
    ((|(pend & unmask)) && st.stby2 && !srst_done) |=> (wake && irq))
    else $error("No wake request for an unmasked flag in standby.");

  a_enable_after_sync: assert property (@(posedge mclk) disable iff (reset)
    (en_launch && !en_busy && apb.pwdata[`CTRL_ENABLE] && !enabled) |=> !enabled [*4])
    else $error("Enable took effect before synchronisation.");

  a_busy_readback: assert property (@(posedge mclk) disable iff (reset)
    (setup && sel_busy && busy_any) |=> (prdata[`BUSY_SOFT_RESET] || prdata[`BUSY_ENABLE]))
    else $error("Busy not shown in the synchronisation status read.");

  a_pending_readback: assert property (@(posedge mclk) disable iff (reset)
    (setup && sel_pend) |=> (prdata[`SOURCES-1:0] == $past(pend)))
    else $error("Pending flag read does not show the flags.");

  a_event_per_source: assert property (@(posedge mclk) disable iff (reset)
    event_out[`SRC_WRAP] |-> $past(hits.wrap && st.core_run))
    else $error("Wrap event without a wrap hit.");

  a_apb_single_ready: assert property (@(posedge mclk) disable iff (reset)
    pready |=> !pready)
    else $error("Ready held for more than one cycle.");

  a_pslverr_unmapped: assert property (@(posedge mclk) disable iff (reset)
    (setup && !mapped) |=> (pready && pslverr))
    else $error("Unmapped access not answered with an error.");

  a_pslverr_mapped: assert property (@(posedge mclk) disable iff (reset)
    (setup && mapped) |=> (pready && !pslverr))
    else $error("Mapped access answered with an error.");

  a_unmapped_reads_zero: assert property (@(posedge mclk) disable iff (reset)
    (setup && !mapped) |=> (prdata == 32'h0000_0000))
    else $error("Unmapped read returned nonzero data.");

  a_wake_needs_standby: assert property (@(posedge mclk) disable iff (reset)
    wake |-> $past(st.stby2))
    else $error("Wake request raised outside standby.");

  a_srst_clears_irq: assert property (@(posedge mclk) disable iff (reset)
    srst_done |=> !irq)
    else $error("Interrupt survived a soft reset.");

  a_srst_clears_flags: assert property (@(posedge mclk) disable iff (reset)
    srst_done |=> !(|pend))
    else $error("Pending flags survived a soft reset.");

  a_srst_stops_core: assert property (@(posedge mclk) disable iff (reset)
    srst_done |=> (!core_run && !enabled))
    else $error("Decoder still enabled after a soft reset.");

  a_srst_pulse_out: assert property (@(posedge mclk) disable iff (reset)
    srst_done |=> core_soft_reset)
    else $error("Soft reset not passed to the decoder core.");

  a_core_needs_enable: assert property (@(posedge mclk) disable iff (reset)
    core_run |-> $past(st.enable_active))
    else $error("Decoder running while not enabled.");

  a_irq_cause_past: assert property (@(posedge mclk) disable iff (reset)
    irq |-> $past(|(pend & unmask)))
    else $error("Interrupt raised without an unmasked pending flag.");

  a_ctrl_busy_ignored: assert property (@(posedge mclk) disable iff (reset)
    (wr && sel_ctrl && busy_any && !srst_done) |=> $stable(decode_mode))
    else $error("Control write taken while synchronisation was busy.");

  a_enable_busy_flag: assert property (@(posedge mclk) disable iff (reset)
    en_launch |=> en_busy)
    else $error("Enable write started without a busy indication.");

  a_event_fault_source: assert property (@(posedge mclk) disable iff (reset)
    event_out[`SRC_FAULT] |-> $past(hits.fault && st.core_run))
    else $error("Fault event without a fault hit.");

  a_event_disabled_quiet: assert property (@(posedge mclk) disable iff (reset)
    !(|evt_en) |=> !(|event_out))
    else $error("Event emitted with all event outputs disabled.");

  a_flag_set_over_clear: assert property (@(posedge mclk) disable iff (reset)
    (src[`SRC_WRAP] && wr && sel_pend && apb.pwdata[`SRC_WRAP] && !srst_done) |=> pend[`SRC_WRAP])
    else $error("Flag clear won over a simultaneous source hit.");

endmodule : position_irq_event

`default_nettype wire

// ===== bench/event_sink.sv
// Model of the event routing fabric and the interrupt controller beside the decoder block.
// Assumes event pulses and the wake level arrive on mclk; the bench clears the model.
`timescale 1ns/1ps
`default_nettype none

module event_sink (
  input  wire logic       mclk,
  input  wire logic       clr,
  input  wire logic [5:0] event_out,
  input  wire logic       wake,
  output var  logic [5:0] seen,
  output var  logic       woke
);
  // Each event line is latched as a routed action until the bench clears it.
  always_ff @(posedge mclk) begin
    if (clr) begin
      seen <= 6'h00;
      woke <= 1'b0;
    end else begin
      seen <= seen | event_out;
      woke <= woke | wake;
    end
  end
endmodule : event_sink

`default_nettype wire

// ===== bench/quadrature_decoder_irq_event_test.sv
// Self-checking bench of the decoder interrupt and event block.
// Assumes the package, the configuration header and the event model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pos_irq_cfg.svh"

module quadrature_decoder_irq_event_test;
  import pos_irq_pkg::*;
  logic         mclk = 1'b0;
  logic         reset = 1'b1;
  apb_req_t     bus = '0;
  hit_t         hits = '0;
  logic         standby_in = 1'b0;
  logic         clr = 1'b1;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [5:0]   event_out;
  logic         irq;
  logic         wake;
  logic         core_run;
  logic         enabled;
  decode_mode_t decode_mode;
  logic [5:0]   seen;
  logic         woke;
  logic         srst_pulse;
  logic         srst_seen;
  int           error_cnt = 0;
  int           checks_done = 0;

  always #12.5 mclk = ~mclk;

  position_irq_event u_position_irq_event (.mclk(mclk), .reset(reset), .apb(bus), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hits(hits), .standby_in(standby_in), .event_out(event_out),
    .irq(irq), .wake(wake), .core_run(core_run), .core_soft_reset(srst_pulse), .enabled(enabled),
    .decode_mode(decode_mode));
  event_sink u_event_sink (.mclk(mclk), .clr(clr), .event_out(event_out), .wake(wake), .seen(seen),
    .woke(woke));

  // Latches the one-cycle soft reset pulse towards the core.
  always @(posedge mclk) begin
    if (reset) begin
      srst_seen <= 1'b0;
    end else if (srst_pulse === 1'b1) begin
      srst_seen <= 1'b1;
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h00000000, got}, {31'h00000000, exp});
  endtask : check_bit

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    bus <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {20'h00000, a}, pwdata: d};
    @(posedge mclk);
    bus.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    bus <= '0;
    @(posedge mclk);
    if (n >= 16) begin
      check_bit(1'b0, 1'b1);
      final_report();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h00000000, q, e);
    check_word(q, exp);
  endtask : rd

  task automatic wait_idle();
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, `OFS_SYNCBUSY, 32'h00000000, q, e);
      n++;
    end while (q !== 32'h00000000 && n < 20);
    if (n >= 20) begin
      check_bit(1'b0, 1'b1);
      final_report();
    end
  endtask : wait_idle

  task automatic pulse(input logic [5:0] h);
    hits <= hit_t'(h);
    @(posedge mclk);
    hits <= '0;
    tick(2);
  endtask : pulse

  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd(`OFS_CTRL, 32'h00000000);
    rd(`OFS_PENDING, 32'h00000000);
    rd(`OFS_UNMASK_SET, 32'h00000000);
    apb(1'b0, 12'h01C, 32'h00000000, q, e);
    check_bit(e, 1'b1);
    check_word(q, 32'h00000000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_enable();
    wr(`OFS_CTRL, 32'h00000002);
    check_bit(enabled, 1'b0);
    rd(`OFS_SYNCBUSY, 32'h00000002);
    wait_idle();
    tick(2);
    rd(`OFS_STATUS, 32'h00000003);
    $display("test enable done");
  endtask : t_enable

  task automatic t_sources();
    wr(`OFS_EVCTRL, 32'h0000003F);
    for (int i = 0; i < 6; i++) begin
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      pulse(6'(1 << i));
      check_word({26'h0, seen}, 32'(1 << i));
      rd(`OFS_PENDING, 32'(1 << i));
      wr(`OFS_PENDING, 32'(1 << i));
      rd(`OFS_PENDING, 32'h00000000);
    end
    wr(`OFS_EVCTRL, 32'h00000000);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    pulse(6'h01);
    check_word({26'h0, seen}, 32'h00000000);
    rd(`OFS_PENDING, 32'h00000001);
    wr(`OFS_PENDING, 32'h00000001);
    $display("test sources done");
  endtask : t_sources

  task automatic t_irq();
    wr(`OFS_UNMASK_SET, 32'h00000001);
    check_bit(irq, 1'b0);
    pulse(6'h01);
    check_bit(irq, 1'b1);
    wr(`OFS_UNMASK_SET, 32'h00000000);
    rd(`OFS_UNMASK_SET, 32'h00000001);
    wr(`OFS_UNMASK_CLEAR, 32'h00000000);
    rd(`OFS_UNMASK_CLEAR, 32'h00000001);
    check_bit(irq, 1'b1);
    wr(`OFS_UNMASK_CLEAR, 32'h00000001);
    tick(2);
    check_bit(irq, 1'b0);
    wr(`OFS_UNMASK_SET, 32'h00000001);
    tick(2);
    check_bit(irq, 1'b1);
    wr(`OFS_PENDING, 32'h00000001);
    tick(2);
    check_bit(irq, 1'b0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_mode();
    wr(`OFS_CTRL, 32'h0000000E);
    wait_idle();
    tick(2);
    check_word({30'h0, decode_mode}, 32'h00000003);
    pulse(6'h0C);
    rd(`OFS_PENDING, 32'h00000000);
    wr(`OFS_CTRL, 32'h00000006);
    wait_idle();
    tick(2);
    pulse(6'h0C);
    rd(`OFS_PENDING, 32'h0000000C);
    wr(`OFS_PENDING, 32'h0000000C);
    $display("test mode done");
  endtask : t_mode

  task automatic t_standby();
    pulse(6'h01);
    standby_in <= 1'b1;
    tick(6);
    check_bit(core_run, 1'b0);
    check_bit(woke, 1'b1);
    pulse(6'h02);
    rd(`OFS_PENDING, 32'h00000001);
    wr(`OFS_CTRL, 32'h00000046);
    wait_idle();
    tick(3);
    check_bit(core_run, 1'b1);
    standby_in <= 1'b0;
    $display("test standby done");
  endtask : t_standby

  task automatic t_soft_reset();
    check_bit(srst_seen, 1'b0);
    wr(`OFS_CTRL, 32'h00000001);
    wait_idle();
    tick(2);
    check_bit(srst_seen, 1'b1);
    rd(`OFS_CTRL, 32'h00000000);
    rd(`OFS_PENDING, 32'h00000000);
    rd(`OFS_UNMASK_SET, 32'h00000000);
    check_bit(irq, 1'b0);
    check_bit(enabled, 1'b0);
    $display("test soft reset done");
  endtask : t_soft_reset

  initial begin
    tick(12);
    reset <= 1'b0;
    clr <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_enable();
    t_sources();
    t_irq();
    t_mode();
    t_standby();
    t_soft_reset();
    final_report();
  end
endmodule : quadrature_decoder_irq_event_test

`default_nettype wire
